// file: core/servo_io_pkg.sv
// Purpose: shared types and constants for the servo host i/o block
// Assumes: one 10 MHz core clock, synchronous active-high reset
// Notes: no software registers; configuration arrives on ports
package servo_io_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int ERR_W = 16;
  localparam int REV_W = 16;
  localparam int PIN_N = 7;
  localparam int POUT_N = 3;
  localparam int SER_BIT_NS = 1000;
  localparam int SER_BIT_CYC =
    (SER_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [ERR_W-1:0] ERR_RST = 16'h0000;
  localparam logic [2:0] ALARM_NONE = 3'h0;

  typedef enum logic [1:0] {
    FMT_SIGN_PULSE = 2'b00,
    FMT_CCW_CW = 2'b01,
    FMT_QUAD = 2'b10
  } ref_fmt_t;

  // input function codes
  typedef enum logic [2:0] {
    FN_NONE = 3'b000,
    FN_SERVO_ON = 3'b001,
    FN_ALARM_RESET = 3'b010,
    FN_FWD_LIMIT = 3'b011,
    FN_REV_LIMIT = 3'b100,
    FN_INHIBIT = 3'b101
  } in_fn_t;

  // output function codes
  typedef enum logic [1:0] {
    OFN_READY = 2'b00,
    OFN_IN_POS = 2'b01,
    OFN_SERVO_ON = 2'b10,
    OFN_WARN = 2'b11
  } out_fn_t;

  typedef struct packed {
    logic phase_a;
    logic phase_a_n;
    logic phase_b;
    logic phase_b_n;
    logic origin;
    logic origin_n;
  } enc_out_t;
endpackage

// file: core/rev_serial_tx.sv
// Purpose: serial transmitter of the revolution count
// Assumes: start is a one-cycle pulse; ignored while busy
// Notes: idle high, one start bit low, lsb first, one stop bit high
`timescale 1ns/10ps
module rev_serial_tx #(
  parameter int W = 16,
  parameter int BIT_CYC = 10
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // request
  input wire logic i_start,
  input wire logic [W-1:0] i_data,
  // line
  output logic o_line,
  output logic o_busy
);
  initial begin
    // counters are 8 and 16 bits wide
    if (BIT_CYC < 1 || BIT_CYC > 65536 || W < 1 || W > 253)
      $error("rev_serial_tx bad parameters");
  end
  logic [W+1:0] sh_q, sh_d;
  logic [15:0] cyc_q, cyc_d;
  logic [7:0] left_q, left_d;
  always_comb begin
    sh_d = sh_q;
    cyc_d = cyc_q;
    left_d = left_q;
    if (left_q == 8'h00) begin
      if (i_start) begin
        sh_d = {1'b1, i_data, 1'b0};
        left_d = 8'(W + 2);
        cyc_d = 16'(BIT_CYC - 1);
      end
    end else if (cyc_q == 16'h0000) begin
      sh_d = {1'b1, sh_q[W+1:1]};
      left_d = left_q - 8'h01;
      cyc_d = 16'(BIT_CYC - 1);
    end else begin
      cyc_d = cyc_q - 16'h0001;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sh_q <= '1;
      cyc_q <= 16'h0000;
      left_q <= 8'h00;
    end else begin
      sh_q <= sh_d;
      cyc_q <= cyc_d;
      left_q <= left_d;
    end
  end
  assign o_line = (left_q == 8'h00) ? 1'b1 : sh_q[0];
  assign o_busy = (left_q != 8'h00);
endmodule // rev_serial_tx

// file: core/servo_host_io.sv
// Purpose: pulse reference decode, alarm and encoder outputs
// Assumes: all pins synchronous to i_core_clk, one step per edge
// Notes: outputs registered; encoder complements in own flops, serial complement inverts the same flop
//
// Summary of operation
// - clear input zeroes error counter in position
// - alarm output off while an error exists
// - alarm cause shown as three-bit code
// - encoder steps re-emitted as quadrature with origin
// - absolute encoder revolution count sent serially
// - programmable pins act per configured function
`timescale 1ns/10ps
module servo_host_io
  import servo_io_pkg::*;
#(
  parameter int ERR_WIDTH = servo_io_pkg::ERR_W,
  parameter int REV_WIDTH = servo_io_pkg::REV_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // position reference from host
  input wire servo_io_pkg::ref_fmt_t i_ref_fmt,
  input wire logic i_ref_pulse_in,
  input wire logic i_ref_sign_in,
  input wire logic i_position_mode,
  input wire logic i_err_counter_clear_in,
  input wire logic i_fb_step,
  input wire logic i_fb_dir,
  // alarm source
  input wire logic i_fault,
  input wire logic [2:0] i_fault_code,
  // encoder side
  input wire logic i_enc_step,
  input wire logic i_enc_dir,
  input wire logic i_enc_index,
  input wire logic i_abs_fitted,
  input wire logic [REV_WIDTH-1:0] i_rev_count,
  input wire logic i_initial_data_request_in,
  // programmable i/o
  input wire logic [servo_io_pkg::PIN_N-1:0] i_prog_in,
  input wire servo_io_pkg::in_fn_t [servo_io_pkg::PIN_N-1:0] i_in_fn,
  input wire servo_io_pkg::out_fn_t [servo_io_pkg::POUT_N-1:0] i_out_fn,
  // outputs
  output logic signed [ERR_WIDTH-1:0] o_err_count,
  output logic o_servo_alarm_out,
  output logic [2:0] o_alarm_code,
  output servo_io_pkg::enc_out_t o_enc,
  output logic o_enc_out_rev_serial,
  output logic o_enc_out_rev_serial_n,
  output logic [servo_io_pkg::POUT_N-1:0] o_prog_out,
  output logic o_servo_on,
  output logic o_alarm_reset,
  output logic o_fwd_limit,
  output logic o_rev_limit,
  output logic o_ref_inhibit
);
  import servo_io_pkg::*;
  initial begin
    if (ERR_WIDTH < 2 || REV_WIDTH < 1) $error("servo_host_io widths");
  end

  // reference decode state
  logic pa_q, pa_d, pb_q, pb_d;
  logic signed [ERR_WIDTH-1:0] err_q, err_d;
  logic signed [1:0] ref_step;
  // programmable input functions
  logic [PIN_N-1:0] fn_on [6];
  logic servo_on_d, alm_rst_d, fwd_d, rev_d, inh_d;

  // per-pin function decode
  // one driver per bit, so no process shares a variable
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      for (genvar f = 0; f < 6; f++) begin : g_fn
        assign fn_on[f][g] = i_prog_in[g] && (i_in_fn[g] == in_fn_t'(f));
      end
    end
  endgenerate
  always_comb begin
    servo_on_d = |fn_on[FN_SERVO_ON];
    alm_rst_d = |fn_on[FN_ALARM_RESET];
    fwd_d = |fn_on[FN_FWD_LIMIT];
    rev_d = |fn_on[FN_REV_LIMIT];
    inh_d = |fn_on[FN_INHIBIT];
  end

  always_comb begin
    pa_d = i_ref_pulse_in;
    pb_d = i_ref_sign_in;
    ref_step = 2'sd0;
    unique case (i_ref_fmt)
      FMT_SIGN_PULSE: begin
        if (i_ref_pulse_in && !pa_q) ref_step = i_ref_sign_in ? -2'sd1 : 2'sd1;
      end
      FMT_CCW_CW: begin
        if (i_ref_pulse_in && !pa_q && !(i_ref_sign_in && !pb_q)) ref_step = 2'sd1;
        else if (i_ref_sign_in && !pb_q && !(i_ref_pulse_in && !pa_q))
          ref_step = -2'sd1;
      end
      FMT_QUAD: begin
        if ((i_ref_pulse_in ^ pa_q) && !(i_ref_sign_in ^ pb_q))
          ref_step = (i_ref_pulse_in ^ i_ref_sign_in) ? 2'sd1 : -2'sd1;
        else if ((i_ref_sign_in ^ pb_q) && !(i_ref_pulse_in ^ pa_q))
          ref_step = (i_ref_pulse_in ^ i_ref_sign_in) ? -2'sd1 : 2'sd1;
      end
      default: ref_step = 2'sd0;
    endcase
    if (inh_d) ref_step = 2'sd0;
  end

  always_comb begin
    err_d = err_q + ERR_WIDTH'(ref_step)
          - (i_fb_step ? (i_fb_dir ? -ERR_WIDTH'(1) : ERR_WIDTH'(1))
                       : ERR_WIDTH'(0));
    if (i_position_mode && i_err_counter_clear_in) err_d = ERR_RST;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      err_q <= ERR_RST;
    end else begin
      pa_q <= pa_d;
      pb_q <= pb_d;
      err_q <= err_d;
    end
  end
  assign o_err_count = err_q;

  // alarm and encoder output state
  logic alarm_d, alarm_q;
  logic [2:0] code_d, code_q;
  logic [1:0] qph_d, qph_q;
  logic org_d, org_q;
  enc_out_t enc_d, enc_q;
  always_comb begin
    alarm_d = !i_fault;
    code_d = i_fault ? i_fault_code : ALARM_NONE;
    // gray walk 00,01,11,10 per encoder step
    qph_d = qph_q;
    if (i_enc_step) qph_d = i_enc_dir ? qph_q - 2'h1 : qph_q + 2'h1;
    org_d = i_enc_index;
    enc_d.phase_a = qph_d[1] ^ qph_d[0];
    enc_d.phase_b = qph_d[1];
    enc_d.origin = org_d;
    enc_d.phase_a_n = !enc_d.phase_a;
    enc_d.phase_b_n = !enc_d.phase_b;
    enc_d.origin_n = !org_d;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      alarm_q <= 1'b0;
      code_q <= ALARM_NONE;
      qph_q <= 2'h0;
      org_q <= 1'b0;
      enc_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    end else begin
      alarm_q <= alarm_d;
      code_q <= code_d;
      qph_q <= qph_d;
      org_q <= org_d;
      enc_q <= enc_d;
    end
  end
  assign o_servo_alarm_out = alarm_q;
  assign o_alarm_code = code_q;
  assign o_enc = enc_q;

  // revolution count sent on request when absolute
  logic req_q, req_d, ser_q, ser_busy, ser_start;
  always_comb begin
    req_d = i_initial_data_request_in;
    ser_start = i_abs_fitted && i_initial_data_request_in && !req_q;
  end
  rev_serial_tx #(.W(REV_WIDTH), .BIT_CYC(SER_BIT_CYC)) u_tx (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(ser_start),
    .i_data(i_rev_count),
    .o_line(ser_q),
    .o_busy(ser_busy)
  );

  // programmable outputs and decoded functions
  logic [POUT_N-1:0] pout_d, pout_q;
  logic [4:0] fn_q;
  generate
    for (g = 0; g < POUT_N; g++) begin : g_out
      assign pout_d[g] =
        (i_out_fn[g] == OFN_READY) ? !i_fault :
        (i_out_fn[g] == OFN_IN_POS) ? (err_q == ERR_RST) :
        (i_out_fn[g] == OFN_SERVO_ON) ? servo_on_d : ser_busy;
    end
  endgenerate
  logic ser_out_q;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      req_q <= 1'b0;
      pout_q <= '0;
      fn_q <= 5'h00;
      ser_out_q <= 1'b1;
    end else begin
      req_q <= req_d;
      pout_q <= pout_d;
      fn_q <= {servo_on_d, alm_rst_d, fwd_d, rev_d, inh_d};
      ser_out_q <= ser_q;
    end
  end
  assign o_prog_out = pout_q;
  assign {o_servo_on, o_alarm_reset, o_fwd_limit, o_rev_limit,
          o_ref_inhibit} = fn_q;
  assign o_enc_out_rev_serial = ser_out_q;
  assign o_enc_out_rev_serial_n = !ser_out_q;

  // checks
  chk_err_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_position_mode && i_err_counter_clear_in |=> o_err_count == 0)
    else $error("error counter not cleared");
  chk_alarm_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_fault |=> !o_servo_alarm_out)
    else $error("alarm output not off on fault");
  chk_alarm_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_fault |=> o_servo_alarm_out)
    else $error("alarm output off without fault");
  chk_alarm_code: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_fault |=> o_alarm_code == $past(i_fault_code))
    else $error("alarm code mismatch");
  chk_enc_comp: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_enc.phase_a != o_enc.phase_a_n && o_enc.origin != o_enc.origin_n)
    else $error("complement lines wrong");
  chk_enc_gray: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_enc_step |=> $stable(o_enc.phase_a) && $stable(o_enc.phase_b))
    else $error("quadrature moved without step");
  sequence s_req_rise;
    i_abs_fitted && i_initial_data_request_in && !req_q && !ser_busy;
  endsequence
  chk_rev_start: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_req_rise |=> ##1 !o_enc_out_rev_serial)
    else $error("no start bit after request");
  chk_ref_step: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_ref_fmt == FMT_SIGN_PULSE && i_ref_pulse_in && !pa_q && !i_ref_sign_in
    && !inh_d && !i_fb_step && !(i_position_mode && i_err_counter_clear_in)
    |=> o_err_count == $past(o_err_count) + 1)
    else $error("sign-pulse step not counted");
  chk_pin_fn: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_prog_in[6] && i_in_fn[6] == FN_SERVO_ON |=> o_servo_on)
    else $error("programmable input function lost");
endmodule // servo_host_io

// file: sim/host_ref_model.sv
// Purpose: host controller model driving the pulse reference
// Assumes: lines change just after a rising edge
// Notes: one step per call; quadrature keeps its phase state
`timescale 1ns/10ps
module host_ref_model
  import servo_io_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // reference lines
  output logic o_pulse,
  output logic o_sign
);
  import servo_io_pkg::*;
  initial begin
    o_pulse = 1'b0;
    o_sign = 1'b0;
  end
  task automatic step(input ref_fmt_t f, input logic rev);
    @(posedge i_core_clk);
    if (f == FMT_QUAD) begin
      if (o_pulse ^ o_sign ^ rev) o_sign <= ~o_sign;
      else o_pulse <= ~o_pulse;
    end else begin
      o_pulse <= (f == FMT_CCW_CW) ? ~rev : 1'b1;
      o_sign <= rev;
      @(posedge i_core_clk);
      o_pulse <= 1'b0;
      if (f == FMT_CCW_CW) o_sign <= 1'b0;
    end
    @(posedge i_core_clk);
  endtask
  // lines low, used only outside quadrature
  task automatic idle();
    @(posedge i_core_clk);
    o_pulse <= 1'b0;
    o_sign <= 1'b0;
  endtask
endmodule // host_ref_model

// file: sim/servo_host_io_test.sv
// Purpose: self-checking bench for the servo host i/o block
// Assumes: 10 MHz clock, inputs driven by nba at rising or falling edge
// Notes: quadrature count sign is not fixed, magnitude is checked
`timescale 1ns/10ps
module servo_host_io_test;
  import servo_io_pkg::*;
  logic clk, rst, mode, clr, fbs, fault, es, ed, eix, abs, req;
  logic fbd;
  ref_fmt_t fmt;
  logic [2:0] fc;
  logic [15:0] rev;
  logic [PIN_N-1:0] pin;
  in_fn_t [PIN_N-1:0] ifn;
  out_fn_t [POUT_N-1:0] ofn;
  logic signed [15:0] err;
  logic servo_alarm_out, ser, ser_n, son, ares, fl, rl, inh, pl, sl;
  logic [2:0] code, pout;
  enc_out_t enc;
  int fails, n_checks;
  host_ref_model host (.i_core_clk(clk), .o_pulse(pl), .o_sign(sl));
  servo_host_io dut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_ref_fmt(fmt), .i_ref_pulse_in(pl), .i_ref_sign_in(sl),
    .i_position_mode(mode), .i_err_counter_clear_in(clr),
    .i_fb_step(fbs), .i_fb_dir(fbd), .i_fault(fault),
    .i_fault_code(fc), .i_enc_step(es), .i_enc_dir(ed),
    .i_enc_index(eix), .i_abs_fitted(abs), .i_rev_count(rev),
    .i_initial_data_request_in(req), .i_prog_in(pin),
    .i_in_fn(ifn), .i_out_fn(ofn), .o_err_count(err),
    .o_servo_alarm_out(servo_alarm_out), .o_alarm_code(code), .o_enc(enc),
    .o_enc_out_rev_serial(ser), .o_enc_out_rev_serial_n(ser_n),
    .o_prog_out(pout), .o_servo_on(son), .o_alarm_reset(ares),
    .o_fwd_limit(fl), .o_rev_limit(rl), .o_ref_inhibit(inh));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic zero();
    @(posedge clk);
    mode <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    settle();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_sign();
    zero();
    fmt <= FMT_SIGN_PULSE;
    repeat (3) host.step(FMT_SIGN_PULSE, 1'b0);
    host.step(FMT_SIGN_PULSE, 1'b1);
    settle();
    cmp("err sign", 16'h0002, err);
    fbs <= 1'b1;
    @(posedge clk);
    fbs <= 1'b0;
    fmt <= ref_fmt_t'(2'b11);
    host.step(FMT_SIGN_PULSE, 1'b0);
    settle();
    cmp("err fb", 16'h0001, err);
    host.idle();
    $display("test sign done");
  endtask
  task automatic t_ccw();
    zero();
    fmt <= FMT_CCW_CW;
    repeat (2) host.step(FMT_CCW_CW, 1'b0);
    repeat (3) host.step(FMT_CCW_CW, 1'b1);
    settle();
    cmp("err ccw", 16'hFFFF, err);
    $display("test ccw done");
  endtask
  task automatic t_quad();
    zero();
    fmt <= FMT_QUAD;
    repeat (4) host.step(FMT_QUAD, 1'b0);
    settle();
    cmp("err quad", 16'h0004, err[15] ? -err : err);
    repeat (4) host.step(FMT_QUAD, 1'b1);
    settle();
    cmp("err quad back", 16'h0000, err);
    $display("test quad done");
  endtask
  task automatic t_clr();
    fmt <= FMT_SIGN_PULSE;
    repeat (2) host.step(FMT_SIGN_PULSE, 1'b0);
    mode <= 1'b0;
    clr <= 1'b1;
    settle();
    cmp("err no mode", 16'h0002, err);
    mode <= 1'b1;
    host.step(FMT_SIGN_PULSE, 1'b0);
    settle();
    cmp("err cleared", 16'h0000, err);
    clr <= 1'b0;
    $display("test clear done");
  endtask
  task automatic t_alm();
    for (int c = 0; c < 8; c++) begin
      fault <= 1'b1;
      fc <= 3'(c);
      settle();
      cmp("alarm on fault", 16'h0000, servo_alarm_out);
      cmp("alarm code", 16'(c), code);
      fault <= 1'b0;
      settle();
      cmp("alarm clear", 16'h0001, servo_alarm_out);
      cmp("code clear", 16'h0000, code);
    end
    $display("test alarm done");
  endtask
  task automatic t_enc();
    logic [1:0] ab[5] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01};
    for (int i = 0; i < 5; i++) begin
      ed <= (i == 4);
      eix <= (i == 3);
      es <= 1'b1;
      @(posedge clk);
      es <= 1'b0;
      settle();
      cmp("enc", {10'h0, ab[i][1], ~ab[i][1], ab[i][0], ~ab[i][0],
        i == 3, i != 3}, 16'(enc));
    end
    eix <= 1'b0;
    $display("test encoder done");
  endtask
  task automatic t_ser();
    int n;
    abs <= 1'b1;
    rev <= 16'hA5C3;
    req <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ser !== 1'b0 && n < 40);
    if (n >= 40) begin
      fails++;
      summarize();
    end
    repeat (5) @(negedge clk);
    for (int i = 0; i < 18; i++) begin
      n = (i == 0) ? 0 : (i == 17) ? 1 : rev[i-1];
      cmp("serial bit", 16'(n), ser);
      cmp("serial comp", 16'(!n), ser_n);
      repeat (SER_BIT_CYC) @(negedge clk);
    end
    req <= 1'b0;
    abs <= 1'b0;
    @(posedge clk);
    req <= 1'b1;
    repeat (30) @(negedge clk);
    cmp("serial no abs", 16'h0001, ser);
    req <= 1'b0;
    $display("test serial done");
  endtask
  task automatic t_prog();
    in_fn_t f;
    in_fn_t [PIN_N-1:0] v;
    for (int k = 0; k < PIN_N; k++) begin
      f = in_fn_t'((k + 4) % 5 + 1);
      v = '{default: FN_NONE};
      v[k] = f;
      ifn <= v;
      pin <= 7'(1 << k);
      settle();
      cmp("prog fn", 16'(5'h10 >> (f - 1)),
        {son, ares, fl, rl, inh});
    end
    v = '{default: FN_NONE};
    v[PIN_N-1] = FN_INHIBIT;
    ifn <= v;
    pin <= 7'h40;
    zero();
    fmt <= FMT_SIGN_PULSE;
    ofn <= '{OFN_WARN, OFN_IN_POS, OFN_READY};
    host.step(FMT_SIGN_PULSE, 1'b0);
    settle();
    cmp("inhibit err", 16'h0000, err);
    cmp("prog out", 16'h0003, pout);
    pin <= '0;
    fault <= 1'b1;
    settle();
    cmp("prog out fault", 16'h0002, pout);
    fault <= 1'b0;
    $display("test prog done");
  endtask
  initial begin
    {rst, mode, clr, fbs, fault, es, ed, eix, abs, req} = 10'h200;
    fbd = 1'b0;
    fmt = FMT_SIGN_PULSE;
    fc = 3'h0;
    rev = 16'h0000;
    pin = '0;
    ifn = '{default: FN_NONE};
    ofn = '{default: OFN_READY};
    fails = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_sign();
    t_ccw();
    t_quad();
    t_clr();
    t_alm();
    t_enc();
    t_ser();
    t_prog();
    summarize();
  end
endmodule // servo_host_io_test
